// ===== src/irqsr_defines.svh
// register offsets, field positions, reset values and fixed counts of the irq routing block
// assumes: included by the package and the design modules by bare name
`ifndef IRQSR_DEFINES_SVH
`define IRQSR_DEFINES_SVH

`define IRQSR_ADDR_W 8
`define IRQSR_OFF_ROUTE 8'h34
`define IRQSR_OFF_ISTAT 8'h40
`define IRQSR_OFF_IMASK 8'h44
`define IRQSR_OFF_CTRL 8'h48
`define IRQSR_OFF_LEVEL 8'h4C
`define IRQSR_ROUTE_IDX 8'h0D
`define IRQSR_ROUTE_RST 8'h00
`define IRQSR_LEVEL_RST 6'h0F
`define IRQSR_CTRL_RST 6'h00
`define IRQSR_FP_HI 7
`define IRQSR_FP_LO 6
`define IRQSR_SP_HI 5
`define IRQSR_SP_LO 4
`define IRQSR_TX_BIT 3
`define IRQSR_FULL_BIT 2
`define IRQSR_NEMPTY_BIT 1
`define IRQSR_OVR_BIT 0
`define IRQSR_FIFO_DEPTH 64
`define IRQSR_PTR_W 6
`define IRQSR_CNT_W 7
`define IRQSR_NUM_EVT 4

`endif

// ===== src/irqsr_pkg.sv
// types shared by the irq routing block
// assumes: irqsr_defines.svh on the include path
`include "irqsr_defines.svh"

package irqsr_pkg;

   typedef enum logic [1:0] {
      IRQSR_RUN_STBY = 2'b00,
      IRQSR_RUN_RX = 2'b01,
      IRQSR_RUN_TX = 2'b10,
      IRQSR_RUN_SLEEP = 2'b11
   } irqsr_run_t;

   // radio events seen by the router, all levels
   typedef struct packed {
      logic sync_det;
      logic addr_match;
      logic rssi;
      logic payload_ready;
      logic check_pass;
      logic tx_done;
      logic data_clk;
   } irqsr_evt_t;

   typedef struct packed {
      logic [1:0] first_pin_rx_selector;
      logic [1:0] second_pin_rx_selector;
      logic second_pin_tx_selector;
   } irqsr_sel_t;

   typedef struct packed {
      logic full;
      logic not_empty;
      logic over_level;
      logic byte_written;
   } irqsr_qstat_t;

endpackage

// ===== src/irqsr_queue.sv
// byte queue with full, empty, level and overrun tracking
// assumes: one clock, flush by one-cycle pulse from the register block
`timescale 1ns/100ps
`include "irqsr_defines.svh"

module irqsr_queue (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // write side
   input wire logic wr_valid,
   input wire logic [7:0] wr_data,
   // read side
   input wire logic rd_req,
   output logic [7:0] rd_data,
   // control and state
   input wire logic flush,
   input wire logic [5:0] level_set,
   output irqsr_pkg::irqsr_qstat_t qstat,
   output logic overrun_evt
);
   import irqsr_pkg::*;

   logic [7:0] mem [0:`IRQSR_FIFO_DEPTH-1];
   logic [`IRQSR_PTR_W-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [`IRQSR_CNT_W-1:0] cnt_r, cnt_nxt;
   logic do_wr, do_rd, full;

   assign full = (cnt_r == `IRQSR_CNT_W'(`IRQSR_FIFO_DEPTH));
   assign do_wr = wr_valid & ~full & ~flush;
   assign do_rd = rd_req & (cnt_r != '0) & ~flush;
   assign rd_data = mem[rp_r];
   // byte arriving into a full queue
   assign overrun_evt = wr_valid & full & ~flush; // R16

   always_comb begin
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      cnt_nxt = cnt_r;
      if (flush) begin
         wp_nxt = '0;
         rp_nxt = '0;
         cnt_nxt = '0;
      end else begin
         if (do_wr) wp_nxt = wp_r + 1'b1;
         if (do_rd) rp_nxt = rp_r + 1'b1;
         cnt_nxt = cnt_r + `IRQSR_CNT_W'(do_wr) - `IRQSR_CNT_W'(do_rd);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge pclk) begin
      if (do_wr) mem[wp_r] <= wr_data;
   end

   always_comb begin
      qstat.full = full;
      qstat.not_empty = (cnt_r != '0);
      qstat.over_level = (cnt_r > {1'b0, level_set});
      qstat.byte_written = do_wr;
   end
endmodule

// ===== src/irqsr_mux.sv
// source selection for the two interrupt pins
// assumes: mode and selectors come from registers, events are levels
`timescale 1ns/100ps
`include "irqsr_defines.svh"

module irqsr_mux (
   // configuration
   input irqsr_pkg::irqsr_run_t run_mode,
   input wire logic [1:0] data_handling_mode,
   input wire logic addr_filt_en,
   input irqsr_pkg::irqsr_sel_t sel,
   // sources
   input irqsr_pkg::irqsr_evt_t evt,
   input irqsr_pkg::irqsr_qstat_t qstat,
   // pin levels before the output flops
   output logic first_pin_d,
   output logic second_pin_d
);
   import irqsr_pkg::*;

   logic cont, pkt, tx;

   assign cont = (data_handling_mode == 2'h0);
   assign pkt = data_handling_mode[1];
   assign tx = (run_mode == IRQSR_RUN_TX);

   // standby shares the rx selections, queue sources included
   always_comb begin
      first_pin_d = 1'b0; // R15
      second_pin_d = 1'b0;
      if (!tx && run_mode != IRQSR_RUN_SLEEP) begin // R6
         if (cont) begin
            first_pin_d = (sel.first_pin_rx_selector == 2'h1) ? evt.rssi : evt.sync_det; // R1
            second_pin_d = evt.data_clk; // R4
         end else begin
            unique case (sel.first_pin_rx_selector)
               2'h3: first_pin_d = (pkt && addr_filt_en) ? evt.addr_match : evt.sync_det; // R2 R3
               2'h2: first_pin_d = qstat.not_empty; // R2 R3
               2'h1: first_pin_d = qstat.byte_written; // R2 R3
               2'h0: first_pin_d = pkt ? evt.payload_ready : 1'b0; // R2 R3 R15
            endcase
            unique case (sel.second_pin_rx_selector)
               2'h3: second_pin_d = qstat.over_level; // R5 R14
               2'h2: second_pin_d = evt.rssi; // R5
               2'h1: second_pin_d = qstat.full; // R5
               2'h0: second_pin_d = pkt ? evt.check_pass : 1'b0; // R5 R15
            endcase
         end
      end else if (tx) begin
         if (cont) second_pin_d = evt.data_clk; // R7
         else second_pin_d = sel.second_pin_tx_selector ? evt.tx_done : qstat.full; // R8
      end
   end
endmodule

// ===== src/irqsr_top.sv
// irq source routing block: apb registers, byte queue, pin routing, interrupt
// assumes: single 250 MHz pclk, async active-low presetn, radio events synchronous
//
// Summary of operation
// R1 - In rx or standby with continuous mode, pin one shows sync except code 01 which shows rssi.
// R2 - In buffered mode, pin one shows sync, queue-not-empty, byte written, or nothing for 00.
// R3 - In packet mode, pin one shows sync or address match, not-empty, byte written, payload ready.
// R4 - In rx or standby with continuous mode, pin two always shows the data clock.
// R5 - In buffered or packet mode, pin two shows level, rssi, full, or nothing/check pass for 00.
// R6 - Queue sources stay selectable and live in standby as well as rx.
// R7 - In tx with continuous mode, pin two shows the data clock whatever bit 3 holds.
// R8 - In tx with buffered or packet mode, bit 3 set picks tx done and clear picks queue full.
// R9 - Bit 2 reads one while the queue is full.
// R10 - Bit 1 reads one while the queue holds data.
// R11 - Bit 0 reads one once an overrun has happened and zero otherwise.
// R12 - Writing one to bit 0 clears the overrun flag and flushes the queue.
// R13 - The routing register sits at index 0x0D and resets to all zero.
// R14 - The queue level setting resets to 001111 and drives the level source.
// R15 - A selector code that picks nothing drives its pin low, and pins follow within a cycle.
// R16 - Overrun sets on a byte into a full queue and holds until cleared or reset.
`timescale 1ns/100ps
`include "irqsr_defines.svh"

module irqsr_top (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // radio side
   input irqsr_pkg::irqsr_evt_t evt,
   input wire logic rx_byte_valid,
   input wire logic [7:0] rx_byte,
   input wire logic host_rd_req,
   output logic [7:0] host_rd_data,
   // pins and interrupt
   output logic first_interrupt_pin,
   output logic second_interrupt_pin,
   output logic irq
);
   import irqsr_pkg::*;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] route_r;
   logic [7:0] route_nxt;
   logic ovr_r;
   logic ovr_nxt;
   logic [5:0] level_r;
   logic [5:0] level_nxt;
   // ctrl: [1:0] run mode, [3:2] data handling mode, [4] addr filter
   logic [5:0] ctrl_r;
   logic [5:0] ctrl_nxt;
   logic [`IRQSR_NUM_EVT-1:0] istat_r;
   logic [`IRQSR_NUM_EVT-1:0] istat_nxt;
   logic [`IRQSR_NUM_EVT-1:0] imask_r;
   logic [`IRQSR_NUM_EVT-1:0] imask_nxt;
   logic [31:0] prdata_nxt;
   logic pready_nxt;
   logic pslverr_nxt;
   logic flush_r;
   logic flush_nxt;
   logic pin0_r;
   logic pin0_nxt;
   logic pin1_r;
   logic pin1_nxt;
   logic irq_r;
   logic irq_nxt;
   logic [7:0] q_head_nxt;

   logic setup, wr, rd, hit;
   logic [7:0] off;
   logic [7:0] route_rd;
   logic [`IRQSR_NUM_EVT-1:0] evt_now, evt_prev_r;
   logic pin0_d, pin1_d, ovr_evt;
   irqsr_qstat_t qstat;
   irqsr_sel_t sel;
   irqsr_run_t run_mode;
   logic [7:0] q_rd;

   // ------------------------------------------------------------
   // submodules
   // ------------------------------------------------------------
   irqsr_queue u_irqsr_queue (
      .pclk(pclk),
      .presetn(presetn),
      .wr_valid(rx_byte_valid),
      .wr_data(rx_byte),
      .rd_req(host_rd_req),
      .rd_data(q_rd),
      .flush(flush_r),
      .level_set(level_r),
      .qstat(qstat),
      .overrun_evt(ovr_evt)
   );

   assign run_mode = irqsr_run_t'(ctrl_r[1:0]);
   assign sel.first_pin_rx_selector = route_r[`IRQSR_FP_HI:`IRQSR_FP_LO];
   assign sel.second_pin_rx_selector = route_r[`IRQSR_SP_HI:`IRQSR_SP_LO];
   assign sel.second_pin_tx_selector = route_r[`IRQSR_TX_BIT];

   irqsr_mux u_irqsr_mux (
      .run_mode(run_mode),
      .data_handling_mode(ctrl_r[3:2]),
      .addr_filt_en(ctrl_r[4]),
      .sel(sel),
      .evt(evt),
      .qstat(qstat),
      .first_pin_d(pin0_d),
      .second_pin_d(pin1_d)
   );

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   // access phase completes in one cycle: pready rises the cycle after setup
   logic sel_route;
   logic sel_istat;
   logic sel_imask;
   logic sel_ctrl;
   logic sel_level;
   logic wr_route;
   logic wr_istat;
   logic wr_imask;
   logic wr_ctrl;
   logic wr_level;
   logic ovr_clr;

   assign setup = psel & ~penable;
   assign off = paddr[7:0];
   assign sel_route = (off == `IRQSR_OFF_ROUTE);
   assign sel_istat = (off == `IRQSR_OFF_ISTAT);
   assign sel_imask = (off == `IRQSR_OFF_IMASK);
   assign sel_ctrl = (off == `IRQSR_OFF_CTRL);
   assign sel_level = (off == `IRQSR_OFF_LEVEL);
   assign hit = (paddr[31:8] == '0) && (paddr[1:0] == 2'h0) &&
                (sel_route || sel_istat || sel_imask || sel_ctrl || sel_level);
   assign wr = psel & penable & pready & pwrite & hit & pstrb[0];
   assign rd = setup & ~pwrite;
   assign wr_route = wr & sel_route;
   assign wr_istat = wr & sel_istat;
   assign wr_imask = wr & sel_imask;
   assign wr_ctrl = wr & sel_ctrl;
   assign wr_level = wr & sel_level;
   // a one in bit 0 of a routing write clears overrun and empties the queue
   assign ovr_clr = wr_route & pwdata[`IRQSR_OVR_BIT]; // R12

   // ------------------------------------------------------------
   // register read view
   // ------------------------------------------------------------
   logic [31:0] rd_word;

   always_comb begin
      route_rd = route_r & 8'hF8; // R13
      route_rd[`IRQSR_FULL_BIT] = qstat.full; // R9
      route_rd[`IRQSR_NEMPTY_BIT] = qstat.not_empty; // R10
      route_rd[`IRQSR_OVR_BIT] = ovr_r; // R11
   end

   always_comb begin
      rd_word = '0;
      unique case (off)
         `IRQSR_OFF_ROUTE: rd_word = {24'h0, route_rd};
         `IRQSR_OFF_ISTAT: rd_word = {28'h0, istat_r};
         `IRQSR_OFF_IMASK: rd_word = {28'h0, imask_r};
         `IRQSR_OFF_CTRL: rd_word = {26'h0, ctrl_r};
         `IRQSR_OFF_LEVEL: rd_word = {26'h0, level_r};
         default: ;
      endcase
   end

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   always_comb begin
      route_nxt = route_r;
      ctrl_nxt = ctrl_r;
      level_nxt = level_r;
      imask_nxt = imask_r;
      // low three bits are live status, never stored
      if (wr_route) route_nxt = {pwdata[7:3], 3'h0}; // R13
      if (wr_ctrl) ctrl_nxt = pwdata[5:0];
      if (wr_level) level_nxt = pwdata[5:0]; // R14
      if (wr_imask) imask_nxt = pwdata[`IRQSR_NUM_EVT-1:0];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         route_r <= `IRQSR_ROUTE_RST; // R13
         ctrl_r <= `IRQSR_CTRL_RST;
         level_r <= `IRQSR_LEVEL_RST; // R14
         imask_r <= '0;
      end else begin
         route_r <= route_nxt;
         ctrl_r <= ctrl_nxt;
         level_r <= level_nxt;
         imask_r <= imask_nxt;
      end
   end

   // ------------------------------------------------------------
   // overrun flag and queue flush
   // ------------------------------------------------------------
   always_comb begin
      ovr_nxt = ovr_r;
      flush_nxt = 1'b0;
      if (ovr_clr) begin
         ovr_nxt = 1'b0; // R12
         flush_nxt = 1'b1; // R12
      end
      // hardware set wins over clear
      if (ovr_evt) ovr_nxt = 1'b1; // R16
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovr_r <= 1'b0;
         flush_r <= 1'b0;
      end else begin
         ovr_r <= ovr_nxt;
         flush_r <= flush_nxt;
      end
   end

   // ------------------------------------------------------------
   // sticky status and interrupt
   // ------------------------------------------------------------
   logic [`IRQSR_NUM_EVT-1:0] evt_rise;

   // rising-edge detect of flag sources for the sticky status
   assign evt_now = {ovr_evt, qstat.full, qstat.over_level, evt.tx_done};
   assign evt_rise = evt_now & ~evt_prev_r;

   always_comb begin
      istat_nxt = istat_r;
      if (wr_istat) istat_nxt = istat_r & ~pwdata[`IRQSR_NUM_EVT-1:0];
      // hardware set wins over clear
      istat_nxt = istat_nxt | evt_rise;
      irq_nxt = |(istat_nxt & imask_nxt);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat_r <= '0;
         evt_prev_r <= '0;
         irq_r <= 1'b0;
      end else begin
         istat_r <= istat_nxt;
         evt_prev_r <= evt_now;
         irq_r <= irq_nxt;
      end
   end

   // ------------------------------------------------------------
   // apb response
   // ------------------------------------------------------------
   always_comb begin
      pready_nxt = setup;
      pslverr_nxt = setup & ~hit;
      prdata_nxt = '0;
      // unmapped reads answer zero with the error flag
      if (rd && hit) prdata_nxt = rd_word;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= prdata_nxt;
         pready <= pready_nxt;
         pslverr <= pslverr_nxt;
      end
   end

   // ------------------------------------------------------------
   // pins and queue head
   // ------------------------------------------------------------
   always_comb begin
      pin0_nxt = pin0_d; // R15
      pin1_nxt = pin1_d;
      q_head_nxt = q_rd;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin0_r <= 1'b0;
         pin1_r <= 1'b0;
         host_rd_data <= '0;
      end else begin
         pin0_r <= pin0_nxt;
         pin1_r <= pin1_nxt;
         host_rd_data <= q_head_nxt;
      end
   end

   assign first_interrupt_pin = pin0_r;
   assign second_interrupt_pin = pin1_r;
   assign irq = irq_r;
endmodule

// ===== verification/irqsr_monitor.sv
// checker on the ports of the irq routing block
// assumes: bound to irqsr_top, one clock domain
`timescale 1ns/100ps

module irqsr_monitor (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // events and pins
   input irqsr_pkg::irqsr_evt_t evt,
   input wire logic first_interrupt_pin,
   input wire logic second_interrupt_pin
);
   import irqsr_pkg::*;
   logic [5:0] ctrl_r;
   // ----------------
   // control mirror
   // ----------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= 6'h00;
      end else if (psel && penable && pready && pwrite && pstrb[0] && paddr == 32'h48) begin
         ctrl_r <= pwdata[5:0];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ready_setup; psel && !penable |=> pready; endproperty
   a_ready_setup: assert property (p_ready_setup) else $error("no pready after setup");
   property p_ready_access; pready |-> psel && penable; endproperty
   a_ready_access: assert property (p_ready_access) else $error("pready outside access");
   property p_ready_single; pready |=> !pready; endproperty
   a_ready_single: assert property (p_ready_single) else $error("pready held too long");
   property p_err_zero; pslverr |-> pready && prdata == 32'h0; endproperty
   a_err_zero: assert property (p_err_zero) else $error("error answer carries data");
   property p_upper_zero; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
   property p_reset_pins; $rose(presetn) |-> !first_interrupt_pin && !second_interrupt_pin;
   endproperty
   a_reset_pins: assert property (p_reset_pins) else $error("pins high after reset");
   property p_recovered_data_clock;
      ctrl_r[3:2] == 2'b00 && ctrl_r[1:0] != 2'b11 |=> second_interrupt_pin == $past(evt.data_clk);
   endproperty
   a_recovered_data_clock: assert property (p_recovered_data_clock) else $error("second pin not data clock");
   property p_sleep; ctrl_r[1:0] == 2'b11 |=> !first_interrupt_pin && !second_interrupt_pin;
   endproperty
   a_sleep: assert property (p_sleep) else $error("pins high in sleep");
endmodule

bind irqsr_top irqsr_monitor u_irqsr_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
   .first_interrupt_pin(first_interrupt_pin), .second_interrupt_pin(second_interrupt_pin));

// ===== verification/irqsr_host_model.sv
// host side: counts rising edges seen on the two interrupt pins
// assumes: pins are registered levels in the pclk domain
`timescale 1ns/100ps

module irqsr_host_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // pins
   input wire logic first_interrupt_pin,
   input wire logic second_interrupt_pin,
   // edge counts
   output logic [15:0] first_edges,
   output logic [15:0] second_edges
);
   logic p1_r, p2_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {p1_r, p2_r, first_edges, second_edges} <= '0;
      end else begin
         p1_r <= first_interrupt_pin;
         p2_r <= second_interrupt_pin;
         first_edges <= first_edges + 16'(first_interrupt_pin && !p1_r);
         second_edges <= second_edges + 16'(second_interrupt_pin && !p2_r);
      end
   end
endmodule

// ===== verification/irq_source_routing_tb.sv
// self-checking bench of the irq routing block
// assumes: apb answers with pready, queue depth 64
`timescale 1ns/100ps

module irq_source_routing_tb;
   import irqsr_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
   logic pready, pslverr, first_interrupt_pin, second_interrupt_pin, irq;
   irqsr_evt_t evt = '0;
   logic rx_byte_valid = 1'b0;
   logic host_rd_req = 1'b0;
   logic [7:0] rx_byte = 8'h00, host_rd_data;
   logic [15:0] first_edges, second_edges;
   int fails = 0, check_count = 0, cyc = 0;
   always #2 pclk = ~pclk;
   irqsr_top u_irqsr_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .evt(evt), .rx_byte_valid(rx_byte_valid),
      .rx_byte(rx_byte), .host_rd_req(host_rd_req), .host_rd_data(host_rd_data),
      .first_interrupt_pin(first_interrupt_pin), .second_interrupt_pin(second_interrupt_pin),
      .irq(irq));
   irqsr_host_model u_irqsr_host_model (.pclk(pclk), .presetn(presetn),
      .first_interrupt_pin(first_interrupt_pin), .second_interrupt_pin(second_interrupt_pin),
      .first_edges(first_edges), .second_edges(second_edges));
   // ----------------
   // helpers
   // ----------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      check(r, x);
   endtask
   task automatic push(input logic [7:0] b);
      @(posedge pclk);
      rx_byte_valid <= 1'b1;
      rx_byte <= b;
      @(posedge pclk);
      rx_byte_valid <= 1'b0;
   endtask
   task automatic pop();
      @(posedge pclk);
      host_rd_req <= 1'b1;
      @(posedge pclk);
      host_rd_req <= 1'b0;
   endtask
   // queue holds one byte, below level
   function automatic logic [1:0] exp_pins(int r, int m, int c, irqsr_evt_t e);
      logic p1, p2;
      p1 = (m == 0) ? ((c == 1) ? e.rssi : e.sync_det) : (c == 3) ? e.sync_det :
         (c == 2) ? 1'b1 : (c == 1 || m == 1) ? 1'b0 : e.payload_ready;
      if (m == 0) p2 = e.data_clk;
      else if (r == 2) p2 = c[0] ? e.tx_done : 1'b0;
      else p2 = (c == 2) ? e.rssi : (c == 0 && m == 2) ? e.check_pass : 1'b0;
      return {p1, p2};
   endfunction
   // ----------------
   // scenarios
   // ----------------
   task automatic t_reset();
      logic [31:0] r;
      logic e;
      rd_chk(32'h34, 32'h00);
      rd_chk(32'h4C, 32'h0F);
      apb(1'b0, 32'h50, 32'h0, r, e);
      check(e, 32'h1);
   endtask
   task automatic t_routing();
      logic [1:0] p;
      for (int r = 0; r < 3; r++)
         for (int m = 0; m < 3; m++)
            for (int c = 0; c < 4; c++) begin
               wr(32'h48, r | (m << 2));
               wr(32'h34, {c[1:0], c[1:0], c[0], 3'b000});
               for (int i = 0; i < 8; i++) begin
                  @(posedge pclk);
                  evt <= irqsr_evt_t'(7'(1 << i));
                  @(posedge pclk);
                  @(posedge pclk);
                  p = exp_pins(r, m, c, evt);
                  if (r != 2) check(first_interrupt_pin, p[1]);
                  check(second_interrupt_pin, p[0]);
               end
            end
      wr(32'h48, 32'h19);
      wr(32'h34, 32'hC0);
      evt <= irqsr_evt_t'(7'h20);
      repeat (2) @(posedge pclk);
      check(first_interrupt_pin, 32'h1);
      wr(32'h48, 32'h03);
      evt <= irqsr_evt_t'(7'h7F);
      repeat (2) @(posedge pclk);
      check(first_interrupt_pin, 32'h0);
      check(second_interrupt_pin, 32'h0);
      evt <= '0;
   endtask
   task automatic t_queue();
      logic [15:0] base;
      wr(32'h48, 32'h05);
      wr(32'h34, 32'h40);
      base = first_edges;
      for (int i = 0; i < 3; i++) push(8'(i));
      repeat (3) @(posedge pclk);
      check(first_edges - base, 32'h3);
      for (int i = 0; i < 60; i++) push(8'(i));
      rd_chk(32'h34, 32'h46);
      push(8'hEE);
      rd_chk(32'h34, 32'h47);
      check(irq, 32'h0);
      wr(32'h44, 32'h08);
      repeat (2) @(posedge pclk);
      check(irq, 32'h1);
      wr(32'h40, 32'h0F);
      repeat (2) @(posedge pclk);
      check(irq, 32'h0);
      rd_chk(32'h34, 32'h47);
      wr(32'h34, 32'h41);
      rd_chk(32'h34, 32'h40);
      push(8'h5A);
      rd_chk(32'h34, 32'h42);
      check(host_rd_data, 32'h5A);
      pop();
      rd_chk(32'h34, 32'h40);
   endtask
   // ----------------
   // run control
   // ----------------
   task automatic results();
      $display("mismatches %0d comparisons %0d", fails, check_count);
      if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         results();
      end
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      push(8'hA5);
      t_routing();
      t_queue();
      results();
   end
endmodule
